// >>> verification/test_timer_master_output_control.sv
// Purpose: bench for the timer second control register block
// Assumes: apb slave answers within the bounded wait
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module test_timer_master_output_control;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic counter_reset = 1'h0, counter_enable = 1'h0, update_event = 1'h0;
  logic commutation_generate = 1'h0, trigger_input = 1'h0, main_output_enable = 1'h1;
  logic dead_time_done = 1'h0, channel_one_pin = 1'h0, channel_two_pin = 1'h0;
  logic channel_three_pin = 1'h0, pready, pslverr, trigger_output, timer_input_one;
  logic [7:0] paddr = 8'h00, edge_count;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] chan_event_flag_set = 4'h0, compare_reference = 4'h0, chan_dma_request;
  logic [3:0] channel_out;
  logic [2:0] channel_comp_out;
  logic [15:0] active_chan_ctrl;
  int err_total = 0, check_count = 0;
  always #10 pclk = ~pclk;
  timer_master_output_control u_timer_master_output_control (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .counter_reset,
    .counter_enable, .update_event, .commutation_generate, .trigger_input,
    .chan_event_flag_set, .compare_reference, .main_output_enable, .dead_time_done,
    .channel_one_pin, .channel_two_pin, .channel_three_pin, .trigger_output,
    .chan_dma_request, .timer_input_one, .channel_out, .channel_comp_out, .active_chan_ctrl);
  trig_slave u_trig_slave (.pclk, .presetn, .trigger_output, .edge_count);
  task automatic end_sim;
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (n == 20) begin
      err_total++;
      end_sim();
    end else begin
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask : apb
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("read", e, rd);
    chk("slave error", 32'h0, 32'(pslverr));
  endtask : rdc
  task automatic tk(int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tk
  // drive each trigger source: the chosen one to v, all others to its inverse
  task automatic src(int c, logic v);
    counter_reset <= (c == 0) ? v : !v;
    counter_enable <= (c == 1) ? v : !v;
    update_event <= (c == 2) ? v : !v;
    chan_event_flag_set <= (c == 3) ? {4{v}} : {4{!v}};
    compare_reference <= {4{!v}} ^ ((c >= 4) ? 4'h1 << (c - 4) : 4'h0);
  endtask : src
  task automatic sc_regs;
    rdc(8'h04, {16'h0000, tmoc_pkg::CTRL2_RESET});
    apb(1'h1, 8'h04, 32'hFFFFFFFF);
    rdc(8'h04, 32'h00007FFD);
    rdc(8'h10, 32'h0);
    apb(1'h1, 8'h44, 32'h1);
    apb(1'h1, 8'h04, 32'h0);
    rdc(8'h04, 32'h00007F00);
    apb(1'h1, 8'h44, 32'h0);
  endtask : sc_regs
  task automatic sc_trig;
    for (int c = 0; c < 8; c++) begin
      apb(1'h1, 8'h04, 32'(c) << 4);
      src(c, 1'h1);
      tk(1);
      chk("trig on", 32'h1, 32'(trigger_output));
      @(posedge pclk);
      src(c, 1'h0);
      tk(1);
      chk("trig off", 32'h0, 32'(trigger_output));
      @(posedge pclk);
      src(8, 1'h1);
    end
    tk(2);
    chk("slave edges", 32'h8, 32'(edge_count));
  endtask : sc_trig
  task automatic sc_dma;
    for (int s = 0; s < 2; s++) begin
      apb(1'h1, 8'h04, 32'(s) << 3);
      chan_event_flag_set <= 4'h5;
      update_event <= 1'h1;
      tk(1);
      chk("dma", (s == 1) ? 32'hF : 32'h5, 32'(chan_dma_request));
      @(posedge pclk);
      chan_event_flag_set <= 4'h0;
      update_event <= 1'h0;
    end
  endtask : sc_dma
  task automatic sc_xor;
    channel_one_pin <= 1'h1;
    channel_two_pin <= 1'h1;
    for (int s = 0; s < 2; s++) begin
      apb(1'h1, 8'h04, 32'(s) << 7);
      tk(6);
      chk("input one", (s == 1) ? 32'h0 : 32'h1, 32'(timer_input_one));
    end
  endtask : sc_xor
  task automatic sc_idle;
    apb(1'h1, 8'h04, 32'h2900);
    main_output_enable <= 1'h0;
    dead_time_done <= 1'h1;
    tk(2);
    chk("idle out", 32'h1, 32'(channel_out));
    chk("idle comp", 32'h6, 32'(channel_comp_out));
    apb(1'h1, 8'h44, 32'h3);
    apb(1'h1, 8'h04, 32'h5400);
    tk(2);
    chk("locked out", 32'h1, 32'(channel_out));
    apb(1'h1, 8'h44, 32'h0);
  endtask : sc_idle
  task automatic sc_preload;
    apb(1'h1, 8'h04, 32'h1);
    apb(1'h1, 8'h20, 32'h7F);
    rdc(8'h24, 32'h08);
    @(posedge pclk);
    commutation_generate <= 1'h1;
    @(posedge pclk);
    commutation_generate <= 1'h0;
    rdc(8'h24, 32'h7F);
    apb(1'h1, 8'h04, 32'h5);
    apb(1'h1, 8'h20, 32'h0);
    rdc(8'h24, 32'h77);
    @(posedge pclk);
    trigger_input <= 1'h1;
    tk(2);
    rdc(8'h24, 32'h0);
    chk("active control", 32'h0, 32'(active_chan_ctrl));
    apb(1'h1, 8'h04, 32'h0);
    apb(1'h1, 8'h20, 32'h0F);
    rdc(8'h24, 32'h0F);
    chk("active control", 32'h0F, 32'(active_chan_ctrl));
  endtask : sc_preload
  // reset, then run the scenarios in order
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    sc_regs();
    sc_trig();
    sc_dma();
    sc_xor();
    sc_idle();
    sc_preload();
    end_sim();
  end
endmodule : test_timer_master_output_control
`default_nettype wire

// >>> verification/tmoc_sva.sv
// Purpose: checker for trigger, dma, idle and read paths
// Assumes: pready always high, so a write lands at its access edge
// Notes: mirrors control and lock writes
`timescale 1ns/1ps
`default_nettype none
module tmoc_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic counter_reset,
  input wire logic update_event,
  input wire logic [3:0] chan_event_flag_set,
  input wire logic [3:0] compare_reference,
  input wire logic main_output_enable,
  input wire logic dead_time_done,
  input wire logic trigger_output,
  input wire logic [3:0] chan_dma_request,
  input wire logic [3:0] channel_out,
  input wire logic [2:0] channel_comp_out
);
  logic [15:0] ctrl_r;
  logic [1:0] lock_r;
  logic wr;
  logic idle;
  assign wr = psel && penable && pwrite;
  assign idle = !main_output_enable && dead_time_done;
  // mirror of control and lock writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 16'h0000;
      lock_r <= 2'h0;
    end else if (wr && paddr == 8'h04) begin
      ctrl_r[7:0] <= pwdata[7:0];
      ctrl_r[15:8] <= (lock_r == 2'h0) ? pwdata[15:8] : ctrl_r[15:8];
    end else if (wr && paddr == 8'h44) begin
      lock_r <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_trig_reset: assert property (ctrl_r[6:4] == 3'h0 |=>
    trigger_output == $past(counter_reset)) else $error("trigger reset source");
  a_trig_pulse: assert property (ctrl_r[6:4] == 3'h3 |=>
    trigger_output == $past(|chan_event_flag_set)) else $error("trigger pulse");
  a_trig_ref: assert property (ctrl_r[6] |=>
    trigger_output == $past(compare_reference[ctrl_r[5:4]])) else $error("trigger ref");
  a_dma_event: assert property (!ctrl_r[3] |=>
    chan_dma_request == $past(chan_event_flag_set)) else $error("dma event");
  a_dma_update: assert property (ctrl_r[3] |=>
    chan_dma_request == {4{$past(update_event)}}) else $error("dma update");
  a_idle_out: assert property (idle |=> channel_out ==
    $past({ctrl_r[14], ctrl_r[12], ctrl_r[10], ctrl_r[8]})) else $error("idle out");
  a_idle_comp: assert property (idle |=> channel_comp_out ==
    $past({ctrl_r[13], ctrl_r[11], ctrl_r[9]})) else $error("idle comp");
  a_ctrl_read: assert property (psel && !pwrite && paddr == 8'h04 |->
    prdata == {16'h0000, ctrl_r & 16'h7FFD}) else $error("control read");
endmodule : tmoc_sva
bind timer_master_output_control tmoc_sva u_tmoc_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .counter_reset, .update_event, .chan_event_flag_set,
  .compare_reference, .main_output_enable, .dead_time_done, .trigger_output,
  .chan_dma_request, .channel_out, .channel_comp_out);
`default_nettype wire

// >>> verification/trig_slave.sv
// Purpose: cascaded slave timer in trigger mode
// Assumes: trigger output is a pclk-domain level
// Notes: counts rising edges of the trigger output
`timescale 1ns/1ps
`default_nettype none
module trig_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trigger_output,
  output logic [7:0] edge_count
);
  logic last_r;
  // rising edge counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 1'h0;
      edge_count <= 8'h00;
    end else begin
      last_r <= trigger_output;
      edge_count <= edge_count + 8'(trigger_output && !last_r);
    end
  end
endmodule : trig_slave
`default_nettype wire

// >>> verilog/timer_master_output_control.sv
// Purpose: second control register of an advanced timer with its effects
// Assumes: APB slave on pclk; timer events are pclk-domain pulses
// Notes: channel pins are asynchronous and pass three flip-flops
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE_01: preload off, control fields apply at once; on, only at commutation
// RULE_02: preload affects only channels 1 to 3, which have complementary outputs
// RULE_03: update source bit adds trigger input rising edge as transfer cause
// RULE_04: DMA source picks channel event or update event for each DMA request
// RULE_05: master source 000 reset, 001 counter enable, 010 update event
// RULE_06: master source 011 pulses trigger output on any channel event flag set
// RULE_07: master source 100 to 111 route compare references 1 to 4
// RULE_08: input 1 select chooses channel 1 pin or XOR of pins 1 to 3
// RULE_09: output 1 takes its idle level after dead time when main output off
// RULE_10: complementary 1 takes its idle level after dead time when main output off
// RULE_11: idle bits ignore writes while write lock level is nonzero
// RULE_12: bits 10 to 14 are idle bits of outputs 2, 2N, 3, 3N, 4
// RULE_13: bits 1 and 15 read zero and ignore writes
module timer_master_output_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counter_reset,
  input wire logic counter_enable,
  input wire logic update_event,
  input wire logic commutation_generate,
  input wire logic trigger_input,
  input wire logic [3:0] chan_event_flag_set,
  input wire logic [3:0] compare_reference,
  input wire logic main_output_enable,
  input wire logic dead_time_done,
  input wire logic channel_one_pin,
  input wire logic channel_two_pin,
  input wire logic channel_three_pin,
  output logic trigger_output,
  output logic [3:0] chan_dma_request,
  output logic timer_input_one,
  output logic [3:0] channel_out,
  output logic [2:0] channel_comp_out,
  output logic [15:0] active_chan_ctrl
);
  logic [15:0] ctrl2_r;
  logic [15:0] chctrl_r;
  logic [15:0] chact_r;
  logic [1:0] write_lock_level_r;
  logic [2:0] pin_sync1_r;
  logic [2:0] pin_sync2_r;
  logic [2:0] pin_sync3_r;
  logic ti1_r;
  logic trig_d_r;
  logic [3:0] dma_r;
  logic [3:0] out_r;
  logic [2:0] comp_r;
  logic wr;
  logic rd;
  logic trig_rise;
  logic transfer;
  logic [15:0] comp_mask;
  logic [15:0] ctrl2_nxt;
  logic [15:0] chact_nxt;

  // chctrl layout: [3:0] output enables, [6:4] comp enables, [15:8] 2-bit modes
  function automatic logic [15:0] comp_chan_mask();
    comp_chan_mask = 16'h3F77;
  endfunction : comp_chan_mask

  // apb decode, zero wait states
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // preload transfer causes
  assign trig_rise = trigger_input & ~trig_d_r;
  assign transfer = commutation_generate
    | (ctrl2_r[tmoc_pkg::UPD_SRC_POS] & trig_rise); // [RULE_03]
  assign comp_mask = comp_chan_mask();

  // ctrl2 write merge with idle lock
  always_comb begin
    ctrl2_nxt = (ctrl2_r & ~tmoc_pkg::CTRL2_WMASK)
      | (pwdata[15:0] & tmoc_pkg::CTRL2_WMASK); // [RULE_13]
    if (write_lock_level_r != 2'h0) begin
      ctrl2_nxt = (ctrl2_nxt & ~tmoc_pkg::IDLE_MASK)
        | (ctrl2_r & tmoc_pkg::IDLE_MASK); // [RULE_11] [RULE_12]
    end
  end

  // ctrl2 register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_r <= tmoc_pkg::CTRL2_RESET;
    end else if (wr && paddr == tmoc_pkg::CTRL2_OFFSET) begin
      ctrl2_r <= ctrl2_nxt;
    end
  end

  // shadow channel control written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chctrl_r <= tmoc_pkg::CHCTRL_RESET;
    end else if (wr && paddr == tmoc_pkg::CHCTRL_OFFSET) begin
      chctrl_r <= pwdata[15:0];
    end
  end

  // write lock level stand-in for the break register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_lock_level_r <= tmoc_pkg::LOCK_RESET;
    end else if (wr && paddr == tmoc_pkg::LOCK_OFFSET) begin
      write_lock_level_r <= pwdata[1:0];
    end
  end

  // active channel control: direct or preloaded per channel
  always_comb begin
    chact_nxt = chact_r;
    if (!ctrl2_r[tmoc_pkg::PRELOAD_POS]) begin
      chact_nxt = chctrl_r; // [RULE_01]
    end else begin
      chact_nxt = (chctrl_r & ~comp_mask) | (chact_r & comp_mask); // [RULE_02]
      if (transfer) begin
        chact_nxt = chctrl_r; // [RULE_01] [RULE_03]
      end
    end
    if (wr && paddr == tmoc_pkg::CHCTRL_OFFSET && !ctrl2_r[tmoc_pkg::PRELOAD_POS]) begin
      chact_nxt = pwdata[15:0]; // [RULE_01]
    end else if (wr && paddr == tmoc_pkg::CHCTRL_OFFSET) begin
      chact_nxt = (pwdata[15:0] & ~comp_mask) | (chact_nxt & comp_mask); // [RULE_02]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chact_r <= tmoc_pkg::CHCTRL_RESET;
    end else begin
      chact_r <= chact_nxt;
    end
  end

  // trigger input edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= trigger_input;
    end
  end

  // dma request source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_r <= 4'h0;
    end else if (ctrl2_r[tmoc_pkg::DMA_SRC_POS]) begin
      dma_r <= {4{update_event}}; // [RULE_04]
    end else begin
      dma_r <= chan_event_flag_set; // [RULE_04]
    end
  end

  // channel pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1_r <= 3'h0;
      pin_sync2_r <= 3'h0;
      pin_sync3_r <= 3'h0;
    end else begin
      pin_sync1_r <= {channel_three_pin, channel_two_pin, channel_one_pin};
      pin_sync2_r <= pin_sync1_r;
      pin_sync3_r <= pin_sync2_r;
    end
  end

  // timer input 1, taken once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ti1_r <= 1'b0;
    end else if (ctrl2_r[tmoc_pkg::XOR_SEL_POS]) begin
      if (pin_sync2_r == pin_sync3_r) begin
        ti1_r <= ^pin_sync3_r; // [RULE_08]
      end
    end else if (pin_sync2_r[0] == pin_sync3_r[0]) begin
      ti1_r <= pin_sync3_r[0]; // [RULE_08]
    end
  end

  // channel outputs: reference while enabled, idle level after dead time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 4'h0;
      comp_r <= 3'h0;
    end else if (main_output_enable) begin
      out_r <= compare_reference & chact_r[3:0];
      comp_r <= ~compare_reference[2:0] & chact_r[6:4];
    end else if (dead_time_done) begin
      out_r <= {ctrl2_r[14], ctrl2_r[12], ctrl2_r[10], ctrl2_r[8]}; // [RULE_09] [RULE_12]
      comp_r <= {ctrl2_r[13], ctrl2_r[11], ctrl2_r[9]}; // [RULE_10] [RULE_12]
    end
  end

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        tmoc_pkg::CTRL2_OFFSET: prdata = {16'h0000, ctrl2_r}; // [RULE_13]
        tmoc_pkg::CHCTRL_OFFSET: prdata = {16'h0000, chctrl_r};
        tmoc_pkg::CHACT_OFFSET: prdata = {16'h0000, chact_r};
        tmoc_pkg::LOCK_OFFSET: prdata = {30'h0000_0000, write_lock_level_r};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  trig_out_sel u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .source(ctrl2_r[6:4]),
    .counter_reset(counter_reset),
    .counter_enable(counter_enable),
    .update_event(update_event),
    .chan_event_flag_set(chan_event_flag_set),
    .compare_reference(compare_reference),
    .trigger_output(trigger_output)
  );

  assign chan_dma_request = dma_r;
  assign timer_input_one = ti1_r;
  assign channel_out = out_r;
  assign channel_comp_out = comp_r;
  assign active_chan_ctrl = chact_r;
endmodule : timer_master_output_control
`default_nettype wire

// >>> verilog/tmoc_pkg.sv
// Purpose: constants for the timer second control register block
// Assumes: APB slave, 32-bit data, 16-bit register in the low bits
// Notes: offsets are byte addresses
package tmoc_pkg;
  localparam logic [7:0] CTRL2_OFFSET = 8'h04;
  localparam logic [7:0] CHCTRL_OFFSET = 8'h20;
  localparam logic [7:0] CHACT_OFFSET = 8'h24;
  localparam logic [7:0] LOCK_OFFSET = 8'h44;
  localparam logic [15:0] CTRL2_RESET = 16'h0000;
  localparam logic [15:0] CTRL2_WMASK = 16'h7FFD;
  localparam logic [15:0] IDLE_MASK = 16'h7F00;
  localparam logic [15:0] CHCTRL_RESET = 16'h0000;
  localparam logic [1:0] LOCK_RESET = 2'h0;
  localparam int PRELOAD_POS = 0;
  localparam int UPD_SRC_POS = 2;
  localparam int DMA_SRC_POS = 3;
  localparam int MMS_LSB = 4;
  localparam int XOR_SEL_POS = 7;
  localparam int IDLE_LSB = 8;
  // channel control: per channel 4 bits {mode[2:0]... } simplified as
  // [3:0]=output enables ch1..4, [6:4]=comp enables ch1..3, [15:8] mode 2b x4
  localparam int NUM_COMP_CH = 3;
  typedef enum logic [2:0] {
    MMS_RESET = 3'b000,
    MMS_ENABLE = 3'b001,
    MMS_UPDATE = 3'b010,
    MMS_PULSE = 3'b011,
    MMS_REF1 = 3'b100,
    MMS_REF2 = 3'b101,
    MMS_REF3 = 3'b110,
    MMS_REF4 = 3'b111
  } mms_type;
endpackage : tmoc_pkg

// >>> verilog/trig_out_sel.sv
// Purpose: trigger output source selection
// Assumes: all inputs on pclk
// Notes: output registered
`timescale 1ns/1ps
`default_nettype none
module trig_out_sel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] source,
  input wire logic counter_reset,
  input wire logic counter_enable,
  input wire logic update_event,
  input wire logic [3:0] chan_event_flag_set,
  input wire logic [3:0] compare_reference,
  output logic trigger_output
);
  tmoc_pkg::mms_type sel;
  logic trg_nxt;
  assign sel = tmoc_pkg::mms_type'(source);
  // source mux
  always_comb begin
    case (sel)
      tmoc_pkg::MMS_RESET: trg_nxt = counter_reset; // [RULE_05]
      tmoc_pkg::MMS_ENABLE: trg_nxt = counter_enable; // [RULE_05]
      tmoc_pkg::MMS_UPDATE: trg_nxt = update_event; // [RULE_05]
      tmoc_pkg::MMS_PULSE: trg_nxt = |chan_event_flag_set; // [RULE_06]
      tmoc_pkg::MMS_REF1: trg_nxt = compare_reference[0]; // [RULE_07]
      tmoc_pkg::MMS_REF2: trg_nxt = compare_reference[1]; // [RULE_07]
      tmoc_pkg::MMS_REF3: trg_nxt = compare_reference[2]; // [RULE_07]
      tmoc_pkg::MMS_REF4: trg_nxt = compare_reference[3]; // [RULE_07]
      default: trg_nxt = 1'b0;
    endcase
  end
  // registered output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_output <= 1'b0;
    end else begin
      trigger_output <= trg_nxt;
    end
  end
endmodule : trig_out_sel
`default_nettype wire
